// file: core/epc_ctrl.sv
`timescale 1ns/1ps
// Contract
// - eight levels for 7 system, 22 interrupts
// - level zero ranks after reset, NMI, hardfault
// - all priority fields reset to zero
// - equal level: lower position wins
// - preemption part alone decides preemption
// - position 0 gives initial stack pointer
// - reset most urgent, drops at first instruction
// - NMI fixed -2, raised only by software
// - unactivatable or disabled faults escalate to hardfault; an enabled imprecise bus fault pends instead
// - memory fault on protection unit mismatch
// - bus fault enableable, precise or imprecise
// - usage fault on undefined or illegal state
// - supervisor call on its instruction
// - debug monitor only enabled and higher
// - pendable service pended only by software
// - system tick pends when timer fires
// - peripheral interrupts from position 16 up
// - only documented interrupt bits exist
// - interrupt needs enable, levels from registers
// - vector fetch parallel with stacking
// - tail-chain without unstack and restack
module epc_ctrl
    import epc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] irqIn,
    input wire logic memFault,
    input wire logic busFaultPrecise,
    input wire logic busFaultImprecise,
    input wire logic usageFault,
    input wire logic svcExec,
    input wire logic debugEvent,
    input wire logic tickFire,
    input wire logic excAck,
    input wire logic excDone,
    input wire logic firstInstr,
    output logic excReq,
    output logic [5:0] excNum,
    output logic vecFetch,
    output logic [7:0] vecAddr,
    output logic stackPush,
    output logic unstackReq
);
    // ****************************************
    // reset release
    // ****************************************
    logic rstMeta;
    logic rstSafeN;


    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta <= 1'b0;
            rstSafeN <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSafeN <= rstMeta;
        end
    end

    epc_state_t cur;
    epc_state_t nx;

    // ****************************************
    // ranking helpers
    // ****************************************
    function automatic logic [3:0] rankOf(input int pos);
        logic [2:0] lvl;
        lvl = 3'h0;
        if (pos < POS_MEM)
            return 4'(pos - 1);
        if (pos < IRQ_BASE)
            lvl = cur.sysPrio[pos];
        else
            lvl = cur.irqPrio[pos - IRQ_BASE];
        return RANK_CFG0 + {1'b0, lvl};
    endfunction

    function automatic logic [3:0] groupOf(input logic [3:0] rank);
        logic [2:0] sub;
        sub = 3'h0;
        if (rank < RANK_CFG0 || rank == RANK_BASE)
            return rank;
        sub = 3'(rank - RANK_CFG0);
        return RANK_CFG0 + {1'b0, sub & (3'h7 << cur.group)};
    endfunction

    function automatic logic [47:0] raiseFault(input logic [47:0] p, input int pos,
        input logic en, input logic [3:0] level);
        if (en && groupOf(rankOf(pos)) < level)
            p[pos] = 1'b1;
        else
            p[POS_HARD] = 1'b1;
        return p;
    endfunction

    function automatic logic [3:0] preemptOf(input int pos);
        return groupOf(rankOf(pos));
    endfunction

    // ****************************************
    // register index helpers
    // ****************************************
    function automatic logic [4:0] irqIdx(input logic [2:0] word, input int k);
        return {word, 2'(k)};
    endfunction

    function automatic logic [3:0] sysIdx(input logic [1:0] word, input int k);
        return {2'(word + 2'h1), 2'(k)};
    endfunction

    function automatic int fieldLsb(input int k);
        return 8 * k + PRIO_LSB;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    logic [47:0] pendEff;
    logic [3:0] bestRank;
    logic [5:0] bestPos;
    logic [3:0] act1;
    logic [3:0] act2;
    logic [5:0] actPos;
    logic [3:0] g;
    logic [31:0] rd;
    logic hit;
    logic acc;
    logic wr;
    logic chainNow;

    always_comb
    begin
        nx = cur;
        nx.irqSync1 = irqIn;
        nx.irqSync2 = cur.irqSync1;
        nx.vecFetch = 1'b0;
        nx.stackPush = 1'b0;
        nx.unstackReq = 1'b0;
        nx.pready = 1'b0;
        nx.pslverr = 1'b0;

        pendEff = cur.pend & ~cur.active & {cur.irqEn & IRQ_IMPL, 16'hFFFF};
        bestRank = RANK_BASE;
        bestPos = 6'h0;
        act1 = RANK_BASE;
        act2 = RANK_BASE;
        actPos = 6'h0;
        g = RANK_BASE;

        for (int i = 1; i < NUM_POS; i++)
        begin
            if (pendEff[i] && rankOf(i) < bestRank)
            begin
                bestRank = rankOf(i);
                bestPos = 6'(i);
            end
            if (cur.active[i])
            begin
                g = groupOf(rankOf(i));
                if (g < act1)
                begin
                    act2 = act1;
                    act1 = g;
                    actPos = 6'(i);
                end
                else if (g < act2)
                begin
                    act2 = g;
                end
            end
        end
        chainNow = bestRank != RANK_BASE && groupOf(bestRank) < act2;

        // ****************************************
        // boot sequence and core handshake
        // ****************************************
        case (cur.boot)
            ST_SP:
            begin
                nx.vecFetch = 1'b1;
                nx.vecAddr = VEC_SP;
                nx.boot = ST_PC;
            end
            ST_PC:
            begin
                nx.vecFetch = 1'b1;
                nx.vecAddr = VEC_RESET;
                nx.boot = ST_RUN;
            end
            ST_RUN:
            begin
                if (excAck && cur.excReq)
                begin
                    nx.pend[cur.excNum] = 1'b0;
                    nx.active[cur.excNum] = 1'b1;
                    nx.vecFetch = 1'b1;
                    nx.vecAddr = {cur.excNum, 2'h0};
                    nx.stackPush = !cur.chained;
                    nx.chained = 1'b0;
                end
                else if (excDone)
                begin
                    nx.active[actPos] = 1'b0;
                    nx.chained = chainNow;
                    nx.unstackReq = !chainNow;
                end
            end
            default:
            begin
                nx.boot = ST_SP;
            end
        endcase
        if (firstInstr)
            nx.active[POS_RESET] = 1'b0;
        nx.excReq = cur.boot == ST_RUN && !(excAck && cur.excReq) && !excDone
            && bestRank != RANK_BASE && groupOf(bestRank) < act1;
        nx.excNum = bestPos;

        // ****************************************
        // register bus
        // ****************************************
        acc = psel && penable && !cur.pready;
        wr = psel && penable && pwrite && cur.pready;
        rd = 32'h0;
        hit = 1'b1;
        if (paddr[11:5] == OFS_IRQ_PRIO[11:5])
        begin
            for (int k = 0; k < 4; k++)
            begin
                rd[fieldLsb(k) +: 3] = cur.irqPrio[irqIdx(paddr[4:2], k)];
                if (wr && IRQ_IMPL[irqIdx(paddr[4:2], k)])
                    nx.irqPrio[irqIdx(paddr[4:2], k)] = pwdata[fieldLsb(k) +: 3];
            end
        end
        else if (paddr[11:4] == OFS_SYS_PRIO[11:4] && paddr[3:2] != 2'h3)
        begin
            for (int k = 0; k < 4; k++)
            begin
                rd[fieldLsb(k) +: 3] = cur.sysPrio[sysIdx(paddr[3:2], k)];
                if (wr && SYS_SETTABLE[sysIdx(paddr[3:2], k)])
                    nx.sysPrio[sysIdx(paddr[3:2], k)] =
                        pwdata[fieldLsb(k) +: 3];
            end
        end
        else
        begin
            case (paddr)
                OFS_EN_SET, OFS_EN_CLR:
                begin
                    rd = cur.irqEn;
                    if (wr && paddr == OFS_EN_SET)
                        nx.irqEn = cur.irqEn | (pwdata & IRQ_IMPL);
                    else if (wr)
                        nx.irqEn = cur.irqEn & ~pwdata;
                end
                OFS_PEND_SET, OFS_PEND_CLR:
                begin
                    rd = cur.pend[47:16];
                    if (wr && paddr == OFS_PEND_SET)
                        nx.pend[47:16] = nx.pend[47:16] | (pwdata & IRQ_IMPL);
                    else if (wr)
                        nx.pend[47:16] = nx.pend[47:16] & ~pwdata;
                end
                OFS_CTRL:
                begin
                    rd[5:0] = actPos;
                    rd[CTL_PENDV_LSB +: 6] = bestPos;
                    rd[CTL_NMI_SET] = cur.pend[POS_NMI];
                    rd[CTL_SVS_SET] = cur.pend[POS_SVS];
                    rd[CTL_TICK_SET] = cur.pend[POS_TICK];
                    if (wr && pwdata[CTL_NMI_SET])
                        nx.pend[POS_NMI] = 1'b1;
                    if (wr && pwdata[CTL_SVS_SET])
                        nx.pend[POS_SVS] = 1'b1;
                    else if (wr && pwdata[CTL_SVS_CLR])
                        nx.pend[POS_SVS] = 1'b0;
                    if (wr && pwdata[CTL_TICK_SET])
                        nx.pend[POS_TICK] = 1'b1;
                    else if (wr && pwdata[CTL_TICK_CLR])
                        nx.pend[POS_TICK] = 1'b0;
                end
                OFS_GROUP:
                begin
                    rd[2:0] = cur.group;
                    if (wr)
                        nx.group = pwdata[2:0] > GROUP_MAX ? GROUP_MAX : pwdata[2:0];
                end
                OFS_SHEN:
                begin
                    rd[3:0] = cur.shEn;
                    if (wr)
                        nx.shEn = pwdata[3:0];
                end
                default:
                begin
                    hit = 1'b0;
                end
            endcase
        end
        if (acc)
        begin
            nx.pready = 1'b1;
            nx.prdata = rd;
            nx.pslverr = !hit;
        end

        // ****************************************
        // hardware events, set after any clear
        // ****************************************
        nx.pend[47:16] = nx.pend[47:16] | (cur.irqSync2 & IRQ_IMPL);
        if (memFault)
            nx.pend = raiseFault(nx.pend, POS_MEM, cur.shEn[SHEN_MEM], act1);
        if (busFaultPrecise)
            nx.pend = raiseFault(nx.pend, POS_BUS, cur.shEn[SHEN_BUS], act1);
        if (busFaultImprecise)
            nx.pend = raiseFault(nx.pend, POS_BUS, cur.shEn[SHEN_BUS], RANK_BASE);
        if (usageFault)
            nx.pend = raiseFault(nx.pend, POS_USAGE, cur.shEn[SHEN_USAGE], act1);
        if (svcExec)
            nx.pend = raiseFault(nx.pend, POS_SVC, 1'b1, act1);
        if (debugEvent && cur.shEn[SHEN_DEBUG] && preemptOf(POS_DEBUG) < act1)
            nx.pend[POS_DEBUG] = 1'b1;
        if (tickFire)
            nx.pend[POS_TICK] = 1'b1;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstSafeN)
    begin
        if (!rstSafeN)
        begin
            cur <= '0;
            cur.active <= ACTIVE_RST;
        end
        else
        begin
            cur <= nx;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign excReq = cur.excReq;
    assign excNum = cur.excNum;
    assign vecFetch = cur.vecFetch;
    assign vecAddr = cur.vecAddr;
    assign stackPush = cur.stackPush;
    assign unstackReq = cur.unstackReq;
endmodule

// file: core/epc_pkg.sv
package epc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] OFS_EN_SET = 12'h000;
    localparam logic [11:0] OFS_EN_CLR = 12'h004;
    localparam logic [11:0] OFS_PEND_SET = 12'h008;
    localparam logic [11:0] OFS_PEND_CLR = 12'h00C;
    localparam logic [11:0] OFS_CTRL = 12'h010;
    localparam logic [11:0] OFS_GROUP = 12'h014;
    localparam logic [11:0] OFS_SHEN = 12'h018;
    localparam logic [11:0] OFS_IRQ_PRIO = 12'h020;
    localparam logic [11:0] OFS_SYS_PRIO = 12'h040;
    // ****************************************
    // field positions
    // ****************************************
    localparam int CTL_NMI_SET = 31;
    localparam int CTL_SVS_SET = 28;
    localparam int CTL_SVS_CLR = 27;
    localparam int CTL_TICK_SET = 26;
    localparam int CTL_TICK_CLR = 25;
    localparam int CTL_PENDV_LSB = 12;
    localparam int SHEN_MEM = 0;
    localparam int SHEN_BUS = 1;
    localparam int SHEN_USAGE = 2;
    localparam int SHEN_DEBUG = 3;
    localparam int PRIO_LSB = 5;
    // ****************************************
    // table positions
    // ****************************************
    localparam int NUM_POS = 48;
    localparam int IRQ_BASE = 16;
    localparam int POS_RESET = 1;
    localparam int POS_NMI = 2;
    localparam int POS_HARD = 3;
    localparam int POS_MEM = 4;
    localparam int POS_BUS = 5;
    localparam int POS_USAGE = 6;
    localparam int POS_SVC = 11;
    localparam int POS_DEBUG = 12;
    localparam int POS_SVS = 14;
    localparam int POS_TICK = 15;
    localparam logic [31:0] IRQ_IMPL = 32'h31FF_C1FF;
    localparam logic [15:0] SYS_SETTABLE = 16'hD870;
    // ****************************************
    // ranks and reset values
    // ****************************************
    localparam logic [3:0] RANK_CFG0 = 4'h3;
    localparam logic [3:0] RANK_BASE = 4'hF;
    localparam logic [2:0] GROUP_MAX = 3'h3;
    localparam logic [47:0] ACTIVE_RST = 48'h0000_0000_0002;
    localparam logic [7:0] VEC_SP = 8'h00;
    localparam logic [7:0] VEC_RESET = 8'h04;

    typedef enum logic [1:0] {ST_SP = 2'h0, ST_PC = 2'h1, ST_RUN = 2'h3} epc_boot_t;

    typedef struct packed {
        epc_boot_t boot;
        logic [31:0] irqSync1;
        logic [31:0] irqSync2;
        logic [31:0] irqEn;
        logic [47:0] pend;
        logic [47:0] active;
        logic [31:0][2:0] irqPrio;
        logic [15:0][2:0] sysPrio;
        logic [2:0] group;
        logic [3:0] shEn;
        logic chained;
        logic excReq;
        logic [5:0] excNum;
        logic vecFetch;
        logic [7:0] vecAddr;
        logic stackPush;
        logic unstackReq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } epc_state_t;
endpackage

// file: verif/epc_ctrl_asserts.sv
`timescale 1ns/1ps
module epc_ctrl_asserts
    import epc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic excAck,
    input wire logic excDone,
    input wire logic firstInstr,
    input wire logic excReq,
    input wire logic [5:0] excNum,
    input wire logic vecFetch,
    input wire logic [7:0] vecAddr,
    input wire logic stackPush,
    input wire logic unstackReq
);
    // ****************
    // boot tracking
    // ****************
    logic firstSeen;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            firstSeen <= 1'b0;
        else if (firstInstr)
            firstSeen <= 1'b1;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_sp;
        $rose(vecFetch) && vecAddr == VEC_SP;
    endsequence
    sequence s_pc;
        vecFetch && vecAddr == VEC_RESET;
    endsequence
    property p_boot; s_sp |=> s_pc; endproperty
    a_boot: assert property (p_boot) else $error("boot vectors out of order");
    property p_quiet; excReq |-> firstSeen; endproperty
    a_quiet: assert property (p_quiet) else $error("request before boot end");
    property p_pos;
        excReq |-> (excNum >= 6'h10 ? IRQ_IMPL[excNum - 6'h10] :
            (SYS_SETTABLE[excNum[3:0]] || excNum inside {6'h02, 6'h03}));
    endproperty
    a_pos: assert property (p_pos) else $error("request for absent position");
    property p_ack;
        excAck && excReq |=> vecFetch && !excReq && vecAddr == {$past(excNum), 2'b00};
    endproperty
    a_ack: assert property (p_ack) else $error("bad entry after ack");
    property p_push; stackPush |-> vecFetch; endproperty
    a_push: assert property (p_push) else $error("stacking without fetch");
    property p_unstack; unstackReq |-> $past(excDone) && !vecFetch; endproperty
    a_unstack: assert property (p_unstack) else $error("stray unstack");
    property p_rdy; psel && penable && !pready |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
endmodule

// file: verif/epc_core_model.sv
`timescale 1ns/1ps
module epc_core_model
    import epc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic excReq,
    input wire logic vecFetch,
    input wire logic [7:0] vecAddr,
    input wire logic ackSlow,
    output logic excAck,
    output logic firstInstr
);
    logic [2:0] waitCnt;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitCnt <= 3'h0;
            excAck <= 1'b0;
            firstInstr <= 1'b0;
        end
        else
        begin
            // core runs once the reset vector is
            firstInstr <= vecFetch && vecAddr == VEC_RESET;
            // take a request at once or after a stall
            excAck <= excReq && !excAck && (!ackSlow || waitCnt == 3'h5);
            waitCnt <= (excReq && !excAck) ? waitCnt + 3'h1 : 3'h0;
        end
    end
endmodule

// file: verif/tb_epc_ctrl.sv
`timescale 1ns/1ps
module tb_epc_ctrl
    import epc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] irqIn = 32'h0;
    logic [6:0] evt = 7'h00;
    logic excDone = 1'b0;
    logic ackSlow = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, excAck, firstInstr, excReq, vecFetch, stackPush, unstackReq;
    logic [5:0] excNum;
    logic [7:0] vecAddr, ex;
    logic [8:0] vq[$];
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int unCnt = 0;
    logic [11:0] ra[12] = '{12'h020, 12'h024, 12'h028, 12'h02C, 12'h030, 12'h034,
        12'h038, 12'h03C, 12'h040, 12'h044, 12'h048, 12'h000};
    logic [31:0] re[12] = '{32'hE0E0E0E0, 32'hE0E0E0E0, 32'h000000E0, 32'hE0E00000,
        32'hE0E0E0E0, 32'hE0E0E0E0, 32'h000000E0, 32'h0000E0E0, 32'h00E0E0E0,
        32'hE0000000, 32'hE0E000E0, 32'h31FFC1FF};
    logic [7:0] offA[7] = '{8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h2C, 8'hFF, 8'h3C};
    logic [7:0] onA[7] = '{8'h10, 8'h14, 8'h14, 8'h18, 8'h2C, 8'h30, 8'h3C};

    epc_ctrl DUT (.clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .irqIn, .memFault(evt[0]), .busFaultPrecise(evt[1]),
        .busFaultImprecise(evt[2]), .usageFault(evt[3]), .svcExec(evt[4]),
        .debugEvent(evt[5]), .tickFire(evt[6]), .excAck, .excDone, .firstInstr,
        .excReq, .excNum, .vecFetch, .vecAddr, .stackPush, .unstackReq);
    epc_core_model core (.clk_sys, .rst_n, .excReq, .vecFetch, .vecAddr, .ackSlow,
        .excAck, .firstInstr);

    always #2.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
    begin
        cyc++;
        if (vecFetch)
            vq.push_back({stackPush, vecAddr});
        if (unstackReq)
            unCnt++;
        if (cyc == 20000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ****************
    // tasks
    // ****************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            error_cnt++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic pulse(input logic [31:0] m);
        irqIn <= m;
        @(posedge clk_sys);
        irqIn <= 32'h0;
    endtask
    task automatic take(input logic [8:0] exp);
        logic [8:0] got;
        got = 9'h0FF;
        for (int i = 0; i < 30 && vq.size() == 0; i++)
            @(posedge clk_sys);
        if (vq.size() > 0)
            got = vq.pop_front();
        check(32'(got), 32'(exp));
    endtask
    task automatic done(input int un);
        int n0;
        n0 = unCnt;
        excDone <= 1'b1;
        @(posedge clk_sys);
        excDone <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check(32'(unCnt - n0), 32'(un));
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check(32'(vq.size()), 32'h2);
        check(32'(vq[0][7:0]), 32'(VEC_SP));
        check(32'(vq[1][7:0]), 32'(VEC_RESET));
        vq.delete();
        for (int i = 0; i < 12; i++)
        begin
            apb(1'b0, ra[i], 32'h0);
            check(rd, 32'h0);
            apb(1'b1, ra[i], 32'hFFFFFFFF);
            apb(1'b0, ra[i], 32'h0);
            check(rd, re[i]);
            apb(1'b1, ra[i], 32'h0);
        end
        apb(1'b1, OFS_EN_CLR, 32'hFFFFFFFF);
        apb(1'b0, 12'h04C, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, OFS_EN_SET, 32'h0000000F);
        pulse(32'h3);
        take(9'h140);
        done(0);
        take(9'h044);
        done(1);
        pulse(32'h10);
        take(9'h0FF);
        ackSlow <= 1'b1;
        apb(1'b1, OFS_IRQ_PRIO, 32'h20400000);
        pulse(32'h4);
        take(9'h148);
        pulse(32'h8);
        take(9'h14C);
        done(1);
        done(1);
        apb(1'b1, OFS_GROUP, 32'h2);
        pulse(32'h4);
        take(9'h148);
        pulse(32'h8);
        take(9'h0FF);
        done(0);
        take(9'h04C);
        done(1);
        ackSlow <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h90000000);
        take(9'h108);
        done(0);
        take(9'h038);
        done(1);
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, OFS_SHEN, k ? 32'hF : 32'h0);
            for (int i = 0; i < 7; i++)
            begin
                evt <= 7'h01 << i;
                @(posedge clk_sys);
                evt <= 7'h00;
                ex = k ? onA[i] : offA[i];
                take({ex != 8'hFF, ex});
                if (ex != 8'hFF)
                    done(1);
            end
        end
        report_and_stop();
    end
endmodule

bind epc_ctrl epc_ctrl_asserts u_chk (.clk_sys, .rst_n, .psel, .penable, .pready, .pslverr,
    .excAck, .excDone, .firstInstr, .excReq, .excNum, .vecFetch, .vecAddr, .stackPush,
    .unstackReq);
